//--- design/rsb_boot_ctrl.sv
// reset strap capture, hard reset sequencing and boot source selection
// assumes an APB master on pclk and host-port word strobes on pclk
//
// Behaviour
// - straps are captured when power-on reset is released
// - boot mode 00 host no PLL, 01 I2C, 10 host with PLL, 11 reserved
// - watchdog strap low disables, high enables the watchdog
// - strobe polarity strap 0 gives active-low, 1 active-high host strobes
// - width strap 0 gives 16-bit, 1 gives 8-bit host port
// - after power-on reset the PLL is bypassed, input clock used directly
// - ROM loader runs first; PLL may be enabled only afterwards
// - host-port boot runs without DMA and polled on both sides
// - host strobe setup comes from polarity and count straps at power-on
// - straps sampled only at power-on release; hard reset keeps them
// - data bit 0 is the least significant bit of each host word
// - hard reset is open-drain; parties only pull it low
// - hard reset released 521 input clocks after power-on release
`timescale 1ns/1ps
module rsb_boot_ctrl
	import rsb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire rsb_apb_req_s apb_req,
	output rsb_apb_rsp_s apb_rsp,
	input wire logic power_on_reset_n,
	input wire rsb_cfg_s strap_pins,
	input wire logic hard_reset_n_in,
	output logic hard_reset_n_out,
	output logic hard_reset_n_oe,
	input wire logic host_wr_valid,
	input wire logic [15:0] host_wr_data,
	output rsb_cfg_s boot_cfg,
	output logic boot_host_sel,
	output logic boot_i2c_sel,
	output logic pll_bypass,
	output logic host_polled,
	output logic host_dma_allow,
	output logic [63:0] boot_group,
	output logic boot_group_valid
);

	// pin synchronisers
	logic por_s;
	logic hrst_s;
	rsb_cfg_s strap_s;

	rsb_sync2 #(.W(2)) u_sync_rst (
		.pclk(pclk),
		.presetn(presetn),
		.d({power_on_reset_n, hard_reset_n_in}),
		.rst_val(2'h1),
		.q({por_s, hrst_s})
	);

	rsb_sync2 #(.W($bits(rsb_cfg_s))) u_sync_strap (
		.pclk(pclk),
		.presetn(presetn),
		.d(strap_pins),
		.rst_val(CFG_RST),
		.q(strap_s)
	);

	// state and registers
	rsb_state_e state_q;
	rsb_state_e state_d;
	rsb_cfg_s cfg_q;
	logic por_q;
	logic [4:0] por_len_q;
	logic por_short_q;
	logic [9:0] cnt_q;
	logic [2:0] oe_hist_q;
	logic hrst_oe_q;
	logic hrst_out_q;
	logic loader_done_q;
	logic pll_en_q;
	logic boot_host_q;
	logic boot_i2c_q;
	logic pll_bypass_q;
	logic host_polled_q;
	logic host_dma_q;
	logic [1:0] word_idx_q;
	logic [47:0] grp_acc_q;
	logic [63:0] boot_group_q;
	logic group_valid_q;
	logic [15:0] group_cnt_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// event decode
	wire por_rise = por_s && !por_q;
	wire ext_hrst = !hrst_s && !hrst_oe_q && (oe_hist_q == 3'h0);
	wire in_reset = (state_q == RSB_POR) || (state_q == RSB_HOLD);
	wire hold_done = (cnt_q == 10'(HRST_CYC - 1));
	wire [9:0] cnt_start = (state_q == RSB_POR) ? 10'(POR_SEEN_LAT) : 10'h000;
	wire wr_take = host_wr_valid && (state_q == RSB_HOST);

	// APB decode
	wire apb_first = apb_req.psel && apb_req.penable && !pready_q;
	wire apb_commit = apb_req.psel && apb_req.penable && pready_q;
	wire hit_status = (apb_req.paddr == ADDR_STATUS);
	wire hit_ctrl = (apb_req.paddr == ADDR_CTRL);
	wire hit_ghi = (apb_req.paddr == ADDR_GROUP_HI);
	wire hit_glo = (apb_req.paddr == ADDR_GROUP_LO);
	wire hit_any = hit_status || hit_ctrl || hit_ghi || hit_glo;
	wire wr_ctrl = apb_commit && apb_req.pwrite && hit_ctrl;
	wire soft_hrst = wr_ctrl && apb_req.pwdata[CTRL_SOFT_HRST_BIT];

	wire [31:0] rd_status = {group_cnt_q, 2'h0, hrst_s, por_short_q, 1'b0, state_q,
		2'h0, cfg_q};
	wire [31:0] rd_ctrl = {30'h0, pll_en_q, loader_done_q};
	wire [31:0] rd_data = hit_status ? rd_status :
		hit_ctrl ? rd_ctrl :
		hit_ghi ? boot_group_q[63:32] :
		hit_glo ? boot_group_q[31:0] : 32'h0;

	// boot sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			RSB_POR: begin
				if (por_rise) begin
					state_d = RSB_HOLD;
				end
			end
			RSB_HOLD: begin
				if (hold_done) begin
					state_d = RSB_LOADER;
				end
			end
			RSB_LOADER: begin
				case (cfg_q.boot_mode)
					BM_HOST_NOPLL, BM_HOST_PLL: state_d = RSB_HOST;
					BM_I2C: state_d = RSB_I2C;
					default: state_d = RSB_IDLE;
				endcase
			end
			RSB_HOST, RSB_I2C: begin
				if (loader_done_q) begin
					state_d = RSB_RUN;
				end
			end
			RSB_IDLE: begin
				state_d = RSB_IDLE;
			end
			RSB_RUN: begin
				state_d = RSB_RUN;
			end
			default: begin
				state_d = RSB_POR;
			end
		endcase
		// hard reset restarts the hold, straps untouched
		if (!in_reset && (ext_hrst || soft_hrst)) begin
			state_d = RSB_HOLD;
		end
		if (!por_s) begin
			state_d = RSB_POR;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= RSB_POR;
			por_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			por_q <= por_s;
			cnt_q <= (state_q == RSB_HOLD) ? cnt_q + 10'h001 : cnt_start;
		end
	end

	// strap capture at power-on release only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= CFG_RST;
		end else if (por_rise) begin
			cfg_q <= strap_s;
		end
	end

	// power-on pulse width watch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_len_q <= '0;
			por_short_q <= 1'b0;
		end else begin
			if (!por_s && (por_len_q != 5'h1F)) begin
				por_len_q <= por_len_q + 5'h01;
			end else if (por_s) begin
				por_len_q <= '0;
			end
			if (por_rise) begin
				por_short_q <= (por_len_q < 5'(POR_MIN_CYC));
			end
		end
	end

	// open-drain hard reset; history masks our own release ramp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hrst_oe_q <= 1'b1;
			hrst_out_q <= 1'b0;
			oe_hist_q <= 3'h7;
		end else begin
			hrst_oe_q <= (state_d == RSB_POR) || (state_d == RSB_HOLD);
			hrst_out_q <= 1'b0;
			oe_hist_q <= {oe_hist_q[1:0], hrst_oe_q};
		end
	end

	// software control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loader_done_q <= 1'b0;
			pll_en_q <= 1'b0;
		end else if (state_d == RSB_POR || state_d == RSB_HOLD) begin
			loader_done_q <= 1'b0;
			pll_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			loader_done_q <= loader_done_q || apb_req.pwdata[CTRL_LOADER_DONE_BIT];
			pll_en_q <= apb_req.pwdata[CTRL_PLL_EN_BIT];
		end
	end

	// boot outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_host_q <= 1'b0;
			boot_i2c_q <= 1'b0;
			pll_bypass_q <= 1'b1;
			host_polled_q <= 1'b0;
			host_dma_q <= 1'b0;
		end else begin
			boot_host_q <= (state_d == RSB_HOST);
			boot_i2c_q <= (state_d == RSB_I2C);
			pll_bypass_q <= !((state_d == RSB_RUN) && pll_en_q &&
				(cfg_q.boot_mode != BM_HOST_NOPLL));
			host_polled_q <= (state_d == RSB_HOST);
			host_dma_q <= (state_d == RSB_RUN);
		end
	end

	// host boot word packer, first word lands in the top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_idx_q <= '0;
			grp_acc_q <= '0;
			boot_group_q <= '0;
			group_valid_q <= 1'b0;
			group_cnt_q <= '0;
		end else begin
			group_valid_q <= 1'b0;
			if (state_q != RSB_HOST) begin
				word_idx_q <= '0;
			end else if (wr_take) begin
				word_idx_q <= word_idx_q + 2'h1;
				grp_acc_q <= {grp_acc_q[31:0], host_wr_data};
				if (word_idx_q == 2'h3) begin
					boot_group_q <= {grp_acc_q, host_wr_data};
					group_valid_q <= 1'b1;
					group_cnt_q <= group_cnt_q + 16'h0001;
				end
			end
		end
	end

	// APB slave, one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_first;
			pslverr_q <= apb_first && !hit_any;
			prdata_q <= (apb_first && !apb_req.pwrite) ? rd_data : 32'h0;
		end
	end

	assign apb_rsp = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};
	assign hard_reset_n_out = hrst_out_q;
	assign hard_reset_n_oe = hrst_oe_q;
	assign boot_cfg = cfg_q;
	assign boot_host_sel = boot_host_q;
	assign boot_i2c_sel = boot_i2c_q;
	assign pll_bypass = pll_bypass_q;
	assign host_polled = host_polled_q;
	assign host_dma_allow = host_dma_q;
	assign boot_group = boot_group_q;
	assign boot_group_valid = group_valid_q;

	// checking helpers
	logic [9:0] since_q;
	logic [15:0] first_word_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_q <= '0;
			first_word_q <= '0;
		end else begin
			if (state_d == RSB_HOLD && state_q != RSB_HOLD) begin
				since_q <= cnt_start + 10'h001;
			end else if (since_q != 10'h3FF) begin
				since_q <= since_q + 10'h001;
			end
			if (wr_take && word_idx_q == 2'h0) begin
				first_word_q <= host_wr_data;
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_strap_capture: assert property (
		por_rise |=> cfg_q == $past(strap_s))
		else $error("straps not captured at power-on release");

	chk_strap_keep: assert property (
		!por_rise |=> $stable(cfg_q))
		else $error("strap configuration changed outside power-on release");

	chk_hrst_release: assert property (
		$fell(hrst_oe_q) |-> since_q == 10'(HRST_CYC + 1))
		else $error("hard reset released at wrong cycle");

	chk_pll_bypass_boot: assert property (
		(state_q == RSB_LOADER || state_q == RSB_HOLD) |-> pll_bypass_q)
		else $error("PLL not bypassed during reset and loader start");

	chk_pll_after_loader: assert property (
		!pll_bypass_q |-> loader_done_q && cfg_q.boot_mode != BM_HOST_NOPLL)
		else $error("PLL enabled before loader done or in no-PLL mode");

	chk_host_polled: assert property (
		boot_host_q |-> host_polled_q && !host_dma_q)
		else $error("host boot not polled or DMA allowed");

	chk_mode_select: assert property (
		state_q == RSB_LOADER && !ext_hrst && por_s |=> boot_i2c_q == (cfg_q.boot_mode == BM_I2C))
		else $error("boot source does not follow boot mode");

	chk_reserved_idle: assert property (
		cfg_q.boot_mode == BM_RESERVED && !in_reset |-> !boot_host_q && !boot_i2c_q)
		else $error("reserved boot mode started a boot source");

	chk_group_order: assert property (
		wr_take && word_idx_q == 2'h3 |=> group_valid_q &&
			boot_group_q[63:48] == $past(first_word_q) &&
			boot_group_q[15:0] == $past(host_wr_data))
		else $error("host boot group words out of order");

	chk_drive_low: assert property (
		hrst_oe_q |-> !hrst_out_q)
		else $error("hard reset driven high");

	chk_apb_wait: assert property (
		apb_first |=> pready_q ##1 !pready_q)
		else $error("APB answer not one wait state");

endmodule

//--- design/rsb_sync2.sv
// two-stage synchroniser for asynchronous pin levels
// assumes inputs are slow levels; no bus coherency across bits is promised
`timescale 1ns/1ps
module rsb_sync2 #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	input wire logic [W-1:0] rst_val,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// level stored relative to the tied reset value, so q resets to rst_val yet follows d
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d ^ rst_val;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q ^ rst_val;

endmodule

//--- include/rsb_pkg.sv
// package for the reset strap and boot select block: map, fields, types
// assumes one 40 MHz clock that is also the reference input clock
package rsb_pkg;

	// clock rates; the device runs straight from the reference input clock
	localparam int PCLK_HZ = 40_000_000;
	localparam int REFERENCE_INPUT_CLOCK_HZ = 40_000_000;
	// reset timing, in reference input clock cycles
	localparam int POR_MIN_REFERENCE_INPUT_CLOCK = 16;
	localparam int HRST_RELEASE_REFERENCE_INPUT_CLOCK = 521;
	localparam int POR_MIN_CYC = (PCLK_HZ / REFERENCE_INPUT_CLOCK_HZ) * POR_MIN_REFERENCE_INPUT_CLOCK;
	localparam int HRST_CYC = (PCLK_HZ / REFERENCE_INPUT_CLOCK_HZ) * HRST_RELEASE_REFERENCE_INPUT_CLOCK;
	// edges from power-on pin rise to the sequencer seeing it: two sync stages, one detect
	localparam int POR_SEEN_LAT = 3;

	// register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_GROUP_HI = 8'h08;
	localparam logic [7:0] ADDR_GROUP_LO = 8'h0C;

	// control register fields
	localparam int CTRL_LOADER_DONE_BIT = 0;
	localparam int CTRL_PLL_EN_BIT = 1;
	localparam int CTRL_SOFT_HRST_BIT = 2;

	// status register fields
	localparam int ST_CFG_LSB = 0;
	localparam int ST_STATE_LSB = 8;
	localparam int ST_POR_SHORT_BIT = 12;
	localparam int ST_HRST_PIN_BIT = 13;
	localparam int ST_GROUPS_LSB = 16;

	// boot mode strap codes
	localparam logic [1:0] BM_HOST_NOPLL = 2'h0;
	localparam logic [1:0] BM_I2C = 2'h1;
	localparam logic [1:0] BM_HOST_PLL = 2'h2;
	localparam logic [1:0] BM_RESERVED = 2'h3;

	typedef struct packed {
		logic byte_mode;
		logic strobe_count;
		logic strobe_pol;
		logic watchdog_en;
		logic [1:0] boot_mode;
	} rsb_cfg_s;

	localparam rsb_cfg_s CFG_RST = '0;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} rsb_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rsb_apb_rsp_s;

	typedef enum logic [2:0] {
		RSB_POR,
		RSB_HOLD,
		RSB_LOADER,
		RSB_HOST,
		RSB_I2C,
		RSB_IDLE,
		RSB_RUN
	} rsb_state_e;

endpackage

//--- tb/rsb_boot_ctrl_test.sv
// self-checking bench for the strap capture and boot select block
// assumes a pull-up on the hard reset wire
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module rsb_boot_ctrl_test
	import rsb_pkg::*;
;
	logic pclk, presetn, power_on_reset_n, send, pull, er, hv, pol, dma, hs, is, byp, bgv;
	logic oe, hout, pull_oe, pin;
	logic [15:0] hd;
	logic [31:0] rd;
	logic [63:0] grp, bg;
	rsb_apb_req_s req;
	rsb_apb_rsp_s rsp;
	rsb_cfg_s straps, bcfg, cfg;
	int bad_count, n_checks;
	assign pin = !((oe && !hout) || pull_oe);
	rsb_boot_ctrl dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.power_on_reset_n(power_on_reset_n), .strap_pins(straps), .hard_reset_n_in(pin),
		.hard_reset_n_out(hout), .hard_reset_n_oe(oe), .host_wr_valid(hv),
		.host_wr_data(hd), .boot_cfg(bcfg), .boot_host_sel(hs), .boot_i2c_sel(is),
		.pll_bypass(byp), .host_polled(pol), .host_dma_allow(dma), .boot_group(bg),
		.boot_group_valid(bgv));
	rsb_host_model host (.pclk(pclk), .send(send), .grp(grp), .pull(pull),
		.host_wr_valid(hv), .host_wr_data(hd), .pull_oe(pull_oe));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
		if (n == 20) begin
			bad_count++;
			close_out;
		end
	endtask
	task wait_oe(input logic v, output int n);
		n = 0;
		while (oe !== v && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		if (n == 1000) begin
			bad_count++;
			close_out;
		end
	endtask
	task por(input rsb_cfg_s c);
		int n;
		power_on_reset_n <= 1'b0;
		straps <= c;
		repeat (20) @(posedge pclk);
		power_on_reset_n <= 1'b1;
		repeat (5) @(posedge pclk);
		straps <= ~c;
		wait_oe(1'b0, n);
		`CHK(n == HRST_CYC - 4, 1'b1)
		`CHK(bcfg, c)
		`CHK(byp, 1'b1)
		repeat (3) @(posedge pclk);
	endtask
	task t_modes;
		rsb_cfg_s c;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			c = {m[0], m[1], ~m[0], m[1], m};
			por(c);
			`CHK(hs, m[0] == 1'b0)
			`CHK(is, m == 2'h1)
			`CHK(pol, m[0] == 1'b0)
			`CHK(dma, 1'b0)
			apb(1'b0, ADDR_STATUS, 32'h0);
			`CHK(rd[5:0], c)
			`CHK(rd[10:8], m == 2'h3 ? 3'h5 : (m == 2'h1 ? 3'h4 : 3'h3))
			apb(1'b1, ADDR_CTRL, 32'h3);
			repeat (3) @(posedge pclk);
			`CHK(byp, m[0] == m[1])
			`CHK(dma, m != 2'h3)
			$display("mode test %0d done", i);
		end
	endtask
	task t_group;
		int n;
		por(6'h00);
		grp <= 64'h0123_4567_89AB_CDEF;
		send <= 1'b1;
		@(posedge pclk);
		send <= 1'b0;
		n = 0;
		while (bgv !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) begin
			bad_count++;
			close_out;
		end
		`CHK(bg, 64'h0123_4567_89AB_CDEF)
		apb(1'b0, ADDR_GROUP_HI, 32'h0);
		`CHK(rd, 32'h0123_4567)
		apb(1'b0, ADDR_GROUP_LO, 32'h0);
		`CHK(rd, 32'h89AB_CDEF)
		apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(rd[10:0], 11'h300)
		apb(1'b0, 8'h40, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		$display("group test done");
	endtask
	task t_hard;
		int n;
		cfg = bcfg;
		repeat (10) @(posedge pclk);
		pull <= 1'b1;
		repeat (6) @(posedge pclk);
		pull <= 1'b0;
		wait_oe(1'b1, n);
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(rd[10:8], 3'h1)
		`CHK(hout, 1'b0)
		wait_oe(1'b0, n);
		`CHK(bcfg, cfg)
		apb(1'b1, ADDR_CTRL, 32'h4);
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK({oe, rd[2:0]}, 4'h8)
		wait_oe(1'b0, n);
		`CHK(n == HRST_CYC - 4, 1'b1)
		`CHK(bcfg, cfg)
		$display("hard reset test done");
	endtask
	initial begin
		presetn = 1'b0;
		power_on_reset_n = 1'b0;
		req = '0;
		straps = '0;
		send = 1'b0;
		pull = 1'b0;
		grp = '0;
		bad_count = 0;
		n_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_modes;
		t_group;
		t_hard;
		close_out;
	end
endmodule

//--- tb/rsb_host_model.sv
// external host model: sends four-word boot groups, pulls hard reset low
// assumes the bench waits out the hard reset release before raising send
`timescale 1ns/1ps
module rsb_host_model
	import rsb_pkg::*;
(
	input wire logic pclk,
	input wire logic send,
	input wire logic [63:0] grp,
	input wire logic pull,
	output logic host_wr_valid,
	output logic [15:0] host_wr_data,
	output logic pull_oe
);
	logic [2:0] cnt_q;
	initial begin
		cnt_q = 3'h0;
		host_wr_valid = 1'b0;
		host_wr_data = 16'h0;
	end
	// words go out most significant first, bit 0 as lsb
	always @(posedge pclk) begin
		if (cnt_q != 3'h0) begin
			host_wr_valid <= 1'b1;
			host_wr_data <= grp[cnt_q*16-1 -: 16];
			cnt_q <= cnt_q - 3'h1;
		end else begin
			host_wr_valid <= 1'b0;
			host_wr_data <= ~host_wr_data;
			if (send) begin
				cnt_q <= 3'h4;
			end
		end
	end
	// only ever pulls the pin low
	assign pull_oe = pull;
endmodule
